// *** atw_conversion_port.sv ***
`timescale 1ns/1ps
module atw_conversion_port
  import atw_pkg::*;
#(
  parameter int unsigned WINDOW_CYCLES    = atw_pkg::WINDOW_CYCLES,
  parameter int unsigned FULL_CONV_CYCLES = atw_pkg::FULL_CONV_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        clockEnable,
  input  wire logic        serialClock,
  input  wire logic        chanSelHi,
  input  wire logic        chanSelLo,
  input  wire logic        faultSenseIn,
  input  wire logic [15:0] convResult,
  output logic             serialResultOut,
  output logic             faultFlagOutN,
  output logic             faultFlagOutNOe,
  output logic             refOutEnable,
  output logic             converterRun,
  output logic [3:0]       inputSelect
);
  import atw_pkg::*;

  // ****************************************
  // declarations
  // ****************************************
  atw_state_e  state;
  logic        fallToggle;
  logic [1:0]  chanAtEdge;
  logic        fallMeta, fallSync, fallPrev;
  logic        sclkMeta, sclkSync, sclkPrev;
  logic        faultMeta, faultSync;
  logic [31:0] windowCount;
  logic [31:0] elapsed;
  logic [2:0]  reductions;
  logic [4:0]  bitsLeft;
  logic [3:0]  bitIdx;
  logic [15:0] resultWord;
  logic        fallEvt, riseEvt, startEvt, shiftEvt, reduceEvt, windowEnd, convDone;
  logic [31:0] convTarget;

  function automatic logic [3:0] chanDecode(input logic [1:0] code);
    chanDecode = 4'h1 << code; // 00 input one .. 11 input four
  endfunction : chanDecode

  // ****************************************
  // link capture and crossings
  // ****************************************
  atw_link_capture linkSide (
    .serialClock (serialClock),
    .resetn      (resetn),
    .chanSelHi   (chanSelHi),
    .chanSelLo   (chanSelLo),
    .fallToggle  (fallToggle),
    .chanAtEdge  (chanAtEdge)
  );

  // two flops per crossing; edge detect only looks at the second stage
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      fallMeta  <= 1'h0;
      fallSync  <= 1'h0;
      fallPrev  <= 1'h0;
      sclkMeta  <= SCLK_IDLE;
      sclkSync  <= SCLK_IDLE;
      sclkPrev  <= SCLK_IDLE;
      faultMeta <= 1'h0;
      faultSync <= 1'h0;
    end else if (clockEnable) begin
      fallMeta  <= fallToggle;
      fallSync  <= fallMeta;
      fallPrev  <= fallSync;
      sclkMeta  <= serialClock;
      sclkSync  <= sclkMeta;
      sclkPrev  <= sclkSync;
      faultMeta <= faultSenseIn;
      faultSync <= faultMeta;
    end
  end

  // ****************************************
  // event decode
  // ****************************************
  assign fallEvt    = fallSync ^ fallPrev;
  assign riseEvt    = sclkSync & ~sclkPrev;
  assign startEvt   = (state == ATW_SLEEP) && fallEvt && (bitsLeft == 5'h0);
  assign shiftEvt   = (state == ATW_SLEEP) && fallEvt && (bitsLeft != 5'h0);
  assign reduceEvt  = (state == ATW_WINDOW) && fallEvt && (reductions < MAX_REDUCE);
  assign windowEnd  = (state == ATW_WINDOW) && (windowCount == 32'(WINDOW_CYCLES - 1));
  assign convTarget = 32'(FULL_CONV_CYCLES) >> reductions;
  assign convDone   = (state == ATW_CONVERT) && (elapsed >= convTarget);

  // ****************************************
  // sequencer
  // ****************************************
  // window opens on the start edge; conversion runs on after it closes
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state <= ATW_SLEEP;
    end else if (clockEnable) begin
      case (state)
        ATW_SLEEP: begin
          if (startEvt) state <= ATW_WINDOW;
        end
        ATW_WINDOW: begin
          if (windowEnd) state <= ATW_CONVERT;
        end
        ATW_CONVERT: begin
          if (convDone) state <= ATW_SLEEP;
        end
        default: state <= ATW_SLEEP;
      endcase
    end
  end

  // window length and total conversion time, both from the start edge
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      windowCount <= 32'h0;
      elapsed     <= 32'h0;
    end else if (clockEnable) begin
      if (startEvt) begin
        windowCount <= 32'h0;
        elapsed     <= 32'h1;
      end else begin
        if (state == ATW_WINDOW) windowCount <= windowCount + 32'h1;
        if (state != ATW_SLEEP) elapsed <= elapsed + 32'h1;
      end
    end
  end

  // reduction count; edges past the sixth are dropped silently
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      reductions <= 3'h0;
    end else if (clockEnable) begin
      if (startEvt) reductions <= 3'h0;
      else if (reduceEvt) reductions <= reductions + 3'h1;
    end
  end

  // channel latched only on the start edge, held through conversion
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      inputSelect <= 4'h1;
    end else if (clockEnable) begin
      if (startEvt) inputSelect <= chanDecode(chanAtEdge);
    end
  end

  // ****************************************
  // result capture and readout
  // ****************************************
  // word taken from the converter at completion; lower resolution keeps
  // the top bits so the sign always leads
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      resultWord <= 16'h0;
      bitsLeft   <= 5'h0;
      bitIdx     <= 4'h0;
    end else if (clockEnable) begin
      if (convDone) begin
        resultWord <= convResult;
        bitsLeft   <= FULL_BITS - {2'h0, reductions};
        bitIdx     <= 4'h0;
      end else if (shiftEvt) begin
        bitsLeft <= bitsLeft - 5'h1;
        bitIdx   <= bitIdx + 4'h1;
      end
    end
  end

  // data line: high after reset, at completion and on start/ack, low when busy, result bits
  // on readout; the ack drops on the next rise or when the window closes
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      serialResultOut <= DATA_OUT_RST;
    end else if (clockEnable) begin
      case (state)
        ATW_SLEEP: begin
          if (startEvt) serialResultOut <= 1'h1;
          else if (shiftEvt) serialResultOut <= resultWord[4'hF - bitIdx];
        end
        ATW_WINDOW: begin
          if (reduceEvt) serialResultOut <= 1'h1;
          else if (riseEvt || windowEnd) serialResultOut <= 1'h0;
        end
        ATW_CONVERT: begin
          serialResultOut <= convDone;
        end
        default: serialResultOut <= DATA_OUT_RST;
      endcase
    end
  end

  // ****************************************
  // fault flag and power gating
  // ****************************************
  // open drain: only ever pulls low, enable tracks the sensed level
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      faultFlagOutN   <= 1'h0;
      faultFlagOutNOe <= 1'h0;
    end else if (clockEnable) begin
      faultFlagOutN   <= 1'h0;
      faultFlagOutNOe <= faultSync;
    end
  end

  // reference and converter live only while awake
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      refOutEnable <= 1'h0;
      converterRun <= 1'h0;
    end else if (clockEnable) begin
      refOutEnable <= startEvt || ((state != ATW_SLEEP) && !convDone);
      converterRun <= startEvt || ((state != ATW_SLEEP) && !convDone);
    end
  end

  // ****************************************
  // checks
  // ****************************************
  logic expectBit;
  assign expectBit = resultWord[4'hF - bitIdx];

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn || !clockEnable);

  sleep_wake_a: assert property (startEvt |=> state == ATW_WINDOW ##1 refOutEnable)
    else $error("start edge did not wake the device");
  chan_capture_a: assert property (startEvt |=> inputSelect == chanDecode($past(chanAtEdge)))
    else $error("channel not latched on start edge");
  chan_hold_a: assert property ((state != ATW_SLEEP) && !startEvt |=> $stable(inputSelect))
    else $error("channel changed during conversion");
  reduce_limit_a: assert property ((state == ATW_WINDOW) && (reductions == MAX_REDUCE) && fallEvt
                                   |=> reductions == MAX_REDUCE)
    else $error("more than six reductions counted");
  busy_low_a: assert property ((state == ATW_CONVERT) && ($past(state) == ATW_CONVERT) |-> !serialResultOut)
    else $error("data line not low while busy");
  shift_bit_a: assert property (shiftEvt |=> serialResultOut == $past(expectBit))
    else $error("wrong readout bit");
  fault_flag_a: assert property (faultSync && $stable(faultSync) [*2] |-> faultFlagOutNOe && !faultFlagOutN)
    else $error("fault flag not pulled low");
  ref_sleep_a: assert property ((state == ATW_SLEEP) && ($past(state) == ATW_SLEEP) && !startEvt
                                |=> !refOutEnable)
    else $error("reference enabled while asleep");
  done_high_a: assert property (convDone |=> serialResultOut && state == ATW_SLEEP
                                && bitsLeft == FULL_BITS - {2'h0, $past(reductions)})
    else $error("completion not signalled");
  ack_a: assert property (reduceEvt |=> serialResultOut)
    else $error("reduction not acknowledged");
  ack_drop_a: assert property ((state == ATW_WINDOW) && riseEvt && !reduceEvt |=> !serialResultOut)
    else $error("ack held past clock rise");
  // a late finish would leave the sequencer in convert past its time, halved once per reduction
  conv_time_a: assert property ((state == ATW_CONVERT) && ($past(state) == ATW_CONVERT)
                                |-> elapsed <= (32'(FULL_CONV_CYCLES) >> reductions))
    else $error("conversion ran past its time");
  win_end_a: assert property (windowEnd && !reduceEvt |=> !serialResultOut && state == ATW_CONVERT)
    else $error("ack held past window end");
endmodule : atw_conversion_port

// *** atw_host_model.sv ***
`timescale 1ns/1ps
// ****************************************
// host side: serial clock and channel select
// ****************************************
module atw_host_model (
  output logic      serialClock,
  output logic      chanSelHi,
  output logic      chanSelLo,
  input  wire logic serialResultOut
);
  logic tick = 1'h0;

  // link tick, offset so its phase is unrelated to the core clock
  initial begin
    #3;
    forever #16 tick = ~tick;
  end

  // clock idles high and stands still between frames
  initial begin
    serialClock = 1'h1;
    chanSelHi   = 1'h0;
    chanSelLo   = 1'h0;
  end

  // one serial clock pulse; two ticks per phase keep each phase over 40 ns
  task automatic pulse(input logic [1:0] sel, output logic lowVal, output logic highVal);
    {chanSelHi, chanSelLo} = sel;
    @(posedge tick);
    serialClock = 1'h0;
    @(posedge tick);
    {chanSelHi, chanSelLo} = ~sel; // pins move once the hold time is over
    @(posedge tick);
    lowVal = serialResultOut;
    serialClock = 1'h1;
    repeat (2) @(posedge tick);
    highVal = serialResultOut;
  endtask : pulse
endmodule : atw_host_model

// *** atw_link_capture.sv ***
`timescale 1ns/1ps
package atw_pkg;
  // ****************************************
  // timing, counts and reset values
  // ****************************************
  localparam int unsigned CLK_MHZ           = 100;
  localparam int unsigned WINDOW_TIME_US    = 100;   // plain default, tune per part
  localparam int unsigned FULL_CONV_TIME_US = 1000;  // plain default, tune per part
  localparam int unsigned WINDOW_CYCLES     = WINDOW_TIME_US * CLK_MHZ;
  localparam int unsigned FULL_CONV_CYCLES  = FULL_CONV_TIME_US * CLK_MHZ;
  localparam logic [2:0]  MAX_REDUCE        = 3'h6;
  localparam logic [4:0]  FULL_BITS         = 5'h10;
  localparam logic        DATA_OUT_RST      = 1'h1;  // line is high out of reset
  localparam logic        SCLK_IDLE         = 1'h1;

  typedef enum logic [1:0] {
    ATW_SLEEP   = 2'h0,
    ATW_WINDOW  = 2'h1,
    ATW_CONVERT = 2'h3
  } atw_state_e;
endpackage : atw_pkg

// ****************************************
// link side: runs on the host serial clock
// ****************************************
module atw_link_capture
  import atw_pkg::*;
(
  input  wire logic       serialClock,
  input  wire logic       resetn,
  input  wire logic       chanSelHi,
  input  wire logic       chanSelLo,
  output logic            fallToggle,
  output logic [1:0]      chanAtEdge
);
  // every falling edge flips the toggle and samples the select pins;
  // the select word only changes on the next edge, so the core can read it
  // once it has seen the toggle move
  always_ff @(negedge serialClock or negedge resetn) begin
    if (!resetn) begin
      fallToggle <= 1'h0;
      chanAtEdge <= 2'h0;
    end else begin
      fallToggle <= ~fallToggle;
      chanAtEdge <= {chanSelHi, chanSelLo};
    end
  end
endmodule : atw_link_capture

// *** atw_testbench.sv ***
`timescale 1ns/1ps
// ****************************************
// bench for the conversion port
// ****************************************
module testbench;
  import atw_pkg::*;
  localparam int unsigned WIN  = 200; // shortened so a run stays brief
  localparam int unsigned FULL = 400;
  logic        clock        = 1'h0;
  logic        resetn       = 1'h0;
  logic        clockEnable  = 1'h1;
  logic        faultSenseIn = 1'h0;
  logic [15:0] convResult   = 16'h0000;
  wire logic   serialClock, chanSelHi, chanSelLo, serialResultOut;
  wire logic   faultFlagOutN, faultFlagOutNOe, refOutEnable, converterRun;
  wire logic [3:0] inputSelect;
  int          badCount = 0;
  int          cmpCount = 0;

  atw_conversion_port #(.WINDOW_CYCLES(WIN), .FULL_CONV_CYCLES(FULL)) uut (
    .clock(clock), .resetn(resetn), .clockEnable(clockEnable), .serialClock(serialClock),
    .chanSelHi(chanSelHi), .chanSelLo(chanSelLo), .faultSenseIn(faultSenseIn),
    .convResult(convResult), .serialResultOut(serialResultOut), .faultFlagOutN(faultFlagOutN),
    .faultFlagOutNOe(faultFlagOutNOe), .refOutEnable(refOutEnable),
    .converterRun(converterRun), .inputSelect(inputSelect));

  atw_host_model host (
    .serialClock(serialClock), .chanSelHi(chanSelHi), .chanSelLo(chanSelLo),
    .serialResultOut(serialResultOut));

  // core clock, 10 ns
  initial begin
    forever #5 clock = ~clock;
  end

  // compare and count; four-state so an unknown never matches
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    cmpCount++;
    if (got !== exp) begin
      badCount++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task automatic endSim;
    $display("checks %0d mismatches %0d", cmpCount, badCount);
    if (badCount == 0 && cmpCount > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : endSim

  // one full start, reduce, convert and read cycle
  task automatic t_conv(input logic [1:0] sel, input int red, input logic [15:0] word);
    logic lo, hi;
    int   r, x, n, el;
    longint t0;
    r = (red > 6) ? 6 : red;
    x = (WIN > (FULL >> r)) ? WIN : (FULL >> r);
    @(posedge clock);
    #1 convResult = word;
    t0 = $time;
    host.pulse(sel, lo, hi);
    check({lo, hi}, 16'h2, "start signature");
    check(inputSelect, 16'h1 << sel, "channel");
    check({refOutEnable, converterRun}, 16'h3, "awake");
    for (int k = 0; k < red; k++) begin
      host.pulse(sel, lo, hi);
      check({lo, hi}, (k < 6) ? 16'h2 : 16'h0, "reduce ack");
    end
    check(serialResultOut, 16'h0, "busy");
    check(inputSelect, 16'h1 << sel, "channel held");
    n = 0;
    while (serialResultOut !== 1'h1 && n < 3000) begin
      @(posedge clock);
      #1 n++;
    end
    el = int'(($time - t0) / 10);
    check(el >= x && el <= x + 12, 16'h1, "duration");
    @(posedge clock);
    #1 check({refOutEnable, converterRun}, 16'h0, "asleep");
    for (int k = 0; k < 16 - r; k++) begin
      host.pulse(~sel, lo, hi);
      check(lo, word[15-k], "result bit");
    end
    $display("test conv sel %0d red %0d done", sel, red);
  endtask : t_conv

  // sense high means below reference, so the flag pulls low
  // first with the core frozen: the flag must not move until enable returns
  task automatic t_fault;
    @(posedge clock);
    #1 clockEnable = 1'h0;
    faultSenseIn = 1'h1;
    repeat (5) @(posedge clock);
    #1 check({faultFlagOutNOe, faultFlagOutN}, 16'h0, "fault frozen");
    clockEnable = 1'h1;
    repeat (5) @(posedge clock);
    #1 check({faultFlagOutNOe, faultFlagOutN}, 16'h2, "fault pull");
    faultSenseIn = 1'h0;
    repeat (5) @(posedge clock);
    #1 check({faultFlagOutNOe, faultFlagOutN}, 16'h0, "fault release");
    $display("test fault done");
  endtask : t_fault

  // outputs while reset is held and just after its release
  task automatic t_reset;
    repeat (8) @(posedge clock);
    #1 check({serialResultOut, refOutEnable, converterRun, inputSelect}, 16'h41, "reset");
    resetn = 1'h1;
    @(posedge clock);
    #1 check({serialResultOut, refOutEnable, converterRun, inputSelect}, 16'h41, "idle");
    $display("test reset done");
  endtask : t_reset

  // main sequence
  initial begin
    t_reset;
    t_conv(2'h0, 0, 16'hA5C3);
    t_conv(2'h1, 1, 16'h1234);
    t_conv(2'h2, 6, 16'hC3A5);
    t_conv(2'h3, 7, 16'h8001);
    t_fault;
    endSim;
  end

  // watchdog, well past the expected run of some 18 us
  initial begin
    #300000;
    badCount++;
    $display("[ERR] %0t watchdog expired", $time);
    endSim;
  end
endmodule : testbench
